//--- afs_consts.vh
// Register offsets, field positions, reset values and the default threshold level
`ifndef AFS_CONSTS_VH
`define AFS_CONSTS_VH
`define AFS_ADDR_MODE_CTRL 8'h02
`define AFS_ADDR_LIMITER 8'h04
`define AFS_ADDR_POWER_DOWN 8'h05
`define AFS_ADDR_FAULT_FLAGS 8'h06
`define AFS_ADDR_FAULT_CLEAR 8'h07
`define AFS_ADDR_SOFT_RESET 8'h08
`define AFS_BIT_OC_AUTOREC 3
`define AFS_BIT_OT_AUTOREC 2
`define AFS_BIT_MODE_SELECT 4
`define AFS_BIT_RIGHT_PD 1
`define AFS_BIT_LEFT_PD 0
`define AFS_BIT_RIGHT_OC 3
`define AFS_BIT_LEFT_OC 2
`define AFS_BIT_OT_WARN 1
`define AFS_BIT_OT_ERR 0
`define AFS_RST_MODE_CTRL 8'h0c
`define AFS_RST_LIMITER 8'h4b
`define AFS_RST_POWER_DOWN 8'h03
`define AFS_RST_FAULT_FLAGS 4'h0
`define AFS_LEVEL_DEFAULT 4'hb
`endif

//--- afs_threshold_decode.v
// Threshold level decoder: percent of supply or fixed power in centiwatts
`timescale 1ns/1ps
`include "afs_consts.vh"
module afs_threshold_decode (
  input wire [3:0] limiter_threshold_level,
  input wire threshold_mode_select,
  output reg [7:0] supply_percent,
  output reg [7:0] power_8ohm_cw,
  output reg [7:0] power_4ohm_cw,
  output wire fixed_power_mode
);
  assign fixed_power_mode = threshold_mode_select;
  always @* begin
    supply_percent = 8'h00;
    power_8ohm_cw = 8'h00;
    power_4ohm_cw = 8'h00;
    if (!threshold_mode_select) begin
      case (limiter_threshold_level)
        4'h0: supply_percent = 8'd64;
        4'h1: supply_percent = 8'd66;
        4'h2: supply_percent = 8'd67;
        4'h3: supply_percent = 8'd69;
        4'h4: supply_percent = 8'd70;
        4'h5: supply_percent = 8'd72;
        4'h6: supply_percent = 8'd74;
        4'h7: supply_percent = 8'd76;
        4'h8: supply_percent = 8'd78;
        4'h9: supply_percent = 8'd80;
        4'ha: supply_percent = 8'd83;
        4'hb: supply_percent = 8'd85;
        4'hc: supply_percent = 8'd88;
        4'hd: supply_percent = 8'd90;
        4'he: supply_percent = 8'd93;
        default: supply_percent = 8'd96;
      endcase
    end else begin
      case (limiter_threshold_level)
        4'h0: begin power_8ohm_cw = 8'd42; power_4ohm_cw = 8'd84; end
        4'h1: begin power_8ohm_cw = 8'd46; power_4ohm_cw = 8'd92; end
        4'h2: begin power_8ohm_cw = 8'd50; power_4ohm_cw = 8'd100; end
        4'h3: begin power_8ohm_cw = 8'd54; power_4ohm_cw = 8'd109; end
        4'h4: begin power_8ohm_cw = 8'd59; power_4ohm_cw = 8'd117; end
        4'h5: begin power_8ohm_cw = 8'd63; power_4ohm_cw = 8'd127; end
        4'h6: begin power_8ohm_cw = 8'd68; power_4ohm_cw = 8'd136; end
        4'h7: begin power_8ohm_cw = 8'd73; power_4ohm_cw = 8'd146; end
        4'h8: begin power_8ohm_cw = 8'd78; power_4ohm_cw = 8'd156; end
        4'h9: begin power_8ohm_cw = 8'd83; power_4ohm_cw = 8'd167; end
        4'ha: begin power_8ohm_cw = 8'd89; power_4ohm_cw = 8'd178; end
        4'hb: begin power_8ohm_cw = 8'd95; power_4ohm_cw = 8'd189; end
        4'hc: begin power_8ohm_cw = 8'd100; power_4ohm_cw = 8'd201; end
        4'hd: begin power_8ohm_cw = 8'd106; power_4ohm_cw = 8'd213; end
        4'he: begin power_8ohm_cw = 8'd113; power_4ohm_cw = 8'd225; end
        default: begin power_8ohm_cw = 8'd119; power_4ohm_cw = 8'd238; end
      endcase
    end
  end
endmodule

//--- afs_sync2.v
// Two flip-flop synchroniser for a vector of fault detector levels
`timescale 1ns/1ps
module afs_sync2 (
  input wire clk,
  input wire nrst,
  input wire [3:0] async_in,
  output reg [3:0] sync_out
);
  reg [3:0] stage1;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 4'h0;
      sync_out <= 4'h0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- afs_fault_regs.v
// Amplifier shutdown, fault flag, fault clear and soft reset register bank
// Functional notes
// - Threshold code decodes to percent or watts
// - Bit 1 at 0x05 powers down right
// - Bit 0 powers down left, reset one
// - Error bit 3: right overcurrent flag
// - Error bit 2: left overcurrent flag
// - Error bit 1: overheat warning flag
// - Error bit 0: overheat error flag
// - Error register read-only, upper bits zero
// - Write to 0x07 clears latched faults
// - Write to 0x08 restores control defaults
// - Mode bit: 0 supply tracking, 1 fixed
// - Threshold level resets to 1011
// - Autorecover enables at 0x02 bits 3,2
`timescale 1ns/1ps
`include "afs_consts.vh"
module afs_fault_regs (
  input wire clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [3:0] fault_detect,
  output reg right_power_down,
  output reg left_power_down,
  output wire overcurrent_autorecover_en,
  output wire overheat_autorecover_en,
  output wire [3:0] limiter_threshold_level,
  output wire threshold_mode_select,
  output wire [7:0] supply_percent,
  output wire [7:0] power_8ohm_cw,
  output wire [7:0] power_4ohm_cw,
  output wire [3:0] fault_active
);
  reg [7:0] mode_ctrl;
  reg [7:0] limiter_ctrl;
  reg [3:0] fault_flags;
  wire [3:0] fault_sync;
  wire wr_mode;
  wire wr_limiter;
  wire wr_power;
  wire fault_clear_hit;
  wire soft_reset_hit;
  wire [3:0] rec_en;
  wire [3:0] next_fault_flags;

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  afs_sync2 u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(fault_detect),
    .sync_out(fault_sync)
  );

  afs_threshold_decode u_dec (
    .limiter_threshold_level(limiter_threshold_level),
    .threshold_mode_select(threshold_mode_select),
    .supply_percent(supply_percent),
    .power_8ohm_cw(power_8ohm_cw),
    .power_4ohm_cw(power_4ohm_cw),
    .fixed_power_mode()
  );

  assign wr_mode = reg_wr && hit(reg_addr, `AFS_ADDR_MODE_CTRL);
  assign wr_limiter = reg_wr && hit(reg_addr, `AFS_ADDR_LIMITER);
  assign wr_power = reg_wr && hit(reg_addr, `AFS_ADDR_POWER_DOWN);
  assign fault_clear_hit = reg_wr && hit(reg_addr, `AFS_ADDR_FAULT_CLEAR);
  assign soft_reset_hit = reg_wr && hit(reg_addr, `AFS_ADDR_SOFT_RESET);

  assign overcurrent_autorecover_en = mode_ctrl[`AFS_BIT_OC_AUTOREC];
  assign overheat_autorecover_en = mode_ctrl[`AFS_BIT_OT_AUTOREC];
  assign limiter_threshold_level = limiter_ctrl[3:0];
  assign threshold_mode_select = limiter_ctrl[`AFS_BIT_MODE_SELECT];

  // Flags are latched only while the matching autorecover bit is set
  assign rec_en[`AFS_BIT_RIGHT_OC] = overcurrent_autorecover_en;
  assign rec_en[`AFS_BIT_LEFT_OC] = overcurrent_autorecover_en;
  assign rec_en[`AFS_BIT_OT_WARN] = overheat_autorecover_en;
  assign rec_en[`AFS_BIT_OT_ERR] = overheat_autorecover_en;

  // Sticky flags: a new detection wins over a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_flag
      assign next_fault_flags[i] = (fault_sync[i] && rec_en[i]) ||
        (fault_flags[i] && !fault_clear_hit && !soft_reset_hit);
    end
  endgenerate

  assign fault_active = fault_flags;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ctrl <= `AFS_RST_MODE_CTRL;
      limiter_ctrl <= `AFS_RST_LIMITER;
      right_power_down <= 1'b1;
      left_power_down <= 1'b1;
      fault_flags <= `AFS_RST_FAULT_FLAGS;
    end else begin
      fault_flags <= next_fault_flags;
      if (soft_reset_hit) begin
        mode_ctrl <= `AFS_RST_MODE_CTRL;
        limiter_ctrl <= `AFS_RST_LIMITER;
        right_power_down <= 1'b1;
        left_power_down <= 1'b1;
      end else begin
        if (wr_mode) begin
          mode_ctrl <= reg_wdata & 8'h3f;
        end
        if (wr_limiter) begin
          limiter_ctrl <= reg_wdata;
        end
        if (wr_power) begin
          right_power_down <= reg_wdata[`AFS_BIT_RIGHT_PD];
          left_power_down <= reg_wdata[`AFS_BIT_LEFT_PD];
        end
      end
    end
  end

  // Registered read data; unmapped and write-only offsets read zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, `AFS_ADDR_MODE_CTRL)) begin
        reg_rdata <= mode_ctrl;
      end else if (hit(reg_addr, `AFS_ADDR_LIMITER)) begin
        reg_rdata <= limiter_ctrl;
      end else if (hit(reg_addr, `AFS_ADDR_POWER_DOWN)) begin
        reg_rdata <= {6'h00, right_power_down, left_power_down};
      end else if (hit(reg_addr, `AFS_ADDR_FAULT_FLAGS)) begin
        reg_rdata <= {4'h0, fault_flags};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule

//--- afs_fault_regs_assertions.sv
// Checker for the fault and shutdown register bank
`timescale 1ns/1ps
module afs_chk (
  input wire clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [3:0] fault_detect,
  input wire right_power_down,
  input wire left_power_down,
  input wire overcurrent_autorecover_en,
  input wire [3:0] fault_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  sequence s_quiet; (fault_detect == 4'h0) [*3]; endsequence
  property p_pdr; s_wr(8'h05) |=> right_power_down == $past(reg_wdata[1]); endproperty
  a_pdr: assert property (p_pdr) else $error("right power down");
  property p_pdl; s_wr(8'h05) |=> left_power_down == $past(reg_wdata[0]); endproperty
  a_pdl: assert property (p_pdl) else $error("left power down");
  property p_rst; s_wr(8'h08) |=> right_power_down && left_power_down && overcurrent_autorecover_en; endproperty
  a_rst: assert property (p_rst) else $error("soft reset");
  property p_ro; reg_rd && reg_addr == 8'h06 |=> reg_rdata == {4'h0, $past(fault_active)}; endproperty
  a_ro: assert property (p_ro) else $error("flag read");
  property p_rz; reg_rd && (reg_addr == 8'h07 || reg_addr == 8'h08) |=> reg_rdata == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("strobe read");
  property p_oc; (fault_detect[3] && overcurrent_autorecover_en && !reg_wr) [*4] |=> fault_active[3]; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent flag");
  property p_nf; $rose(fault_active[2]) |-> $past(overcurrent_autorecover_en); endproperty
  a_nf: assert property (p_nf) else $error("flag while disabled");
  property p_clr; s_quiet ##1 s_wr(8'h07) |=> fault_active == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("fault clear");
endmodule
bind afs_fault_regs afs_chk i_afs_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fault_detect, .right_power_down, .left_power_down, .overcurrent_autorecover_en, .fault_active);

//--- afs_host.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module afs_host (
  input wire clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire [7:0] reg_rdata
);
  // A write to the clear offset or the soft reset offset is how latched faults are recovered
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule

//--- afs_fault_regs_tb.sv
// Testbench for the fault and shutdown register bank
`timescale 1ns/1ps
module afs_fault_regs_tb;
  logic clk = 0;
  logic nrst = 0;
  logic [3:0] fault_detect = 4'h0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, sp, p8, p4;
  wire reg_wr, reg_rd, rpd, lpd, oce, ote, msel;
  wire [3:0] lvl, fa;
  logic [7:0] d;
  int miscompares = 0, num_checks = 0, cyc = 0;
  int tbl[16] = '{64, 66, 67, 69, 70, 72, 74, 76, 78, 80, 83, 85, 88, 90, 93, 96};
  always #10 clk = ~clk;
  afs_host i_afs_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  afs_fault_regs i_afs_fault_regs (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_detect(fault_detect),
    .right_power_down(rpd), .left_power_down(lpd), .overcurrent_autorecover_en(oce),
    .overheat_autorecover_en(ote), .limiter_threshold_level(lvl), .threshold_mode_select(msel),
    .supply_percent(sp), .power_8ohm_cw(p8), .power_4ohm_cw(p4), .fault_active(fa));
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    i_afs_host.rd(a, d);
    chk(d, e);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1;
    rc(8'h05, 8'h03);
    rc(8'h02, 8'h0c);
    rc(8'h04, 8'h4b);
    chk({1'b0, oce, ote, msel, lvl}, 8'h6b);
    rc(8'h06, 8'h00);
    rc(8'h09, 8'h00);
    i_afs_host.wr(8'h05, 8'h02);
    chk({6'h00, rpd, lpd}, 8'h02);
    for (int i = 0; i < 16; i++) begin
      i_afs_host.wr(8'h04, 8'(i));
      chk(sp, 8'(tbl[i]));
    end
    i_afs_host.wr(8'h04, 8'h1f);
    chk(p8, 8'h77);
    chk(p4, 8'hee);
    chk(sp, 8'h00);
    chk({1'b0, oce, ote, msel, lvl}, 8'h7f);
    i_afs_host.wr(8'h04, 8'h10);
    chk(p8, 8'h2a);
    chk(p4, 8'h54);
    fault_detect = 4'hf;
    repeat (5) @(negedge clk);
    i_afs_host.wr(8'h06, 8'h00);
    rc(8'h06, 8'h0f);
    chk({4'h0, fa}, 8'h0f);
    fault_detect = 4'h0;
    repeat (3) @(negedge clk);
    i_afs_host.wr(8'h07, 8'h5a);
    rc(8'h06, 8'h00);
    chk({4'h0, fa}, 8'h00);
    rc(8'h07, 8'h00);
    i_afs_host.wr(8'h02, 8'h00);
    chk({1'b0, oce, ote, msel, lvl}, 8'h10);
    fault_detect = 4'hf;
    repeat (5) @(negedge clk);
    rc(8'h06, 8'h00);
    i_afs_host.wr(8'h08, 8'h33);
    rc(8'h02, 8'h0c);
    rc(8'h04, 8'h4b);
    rc(8'h05, 8'h03);
    rc(8'h08, 8'h00);
    rc(8'h06, 8'h0f);
    // Hardware reset in mid-run must restore defaults and drop the flags
    i_afs_host.wr(8'h05, 8'h00);
    chk({6'h00, rpd, lpd}, 8'h00);
    fault_detect = 4'h0;
    nrst = 0;
    repeat (2) @(negedge clk);
    chk({6'h00, rpd, lpd}, 8'h03);
    nrst = 1;
    rc(8'h06, 8'h00);
    chk({1'b0, oce, ote, msel, lvl}, 8'h6b);
    conclude;
  end
endmodule
